// ---- acs_regs.svh ----
/*
  Register offsets, field positions, reset values and timing counts for the
  converter channel select and control block.
  Assumes inclusion by bare name from the package only.
*/
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ACS_OFF_B        4'h3
`define ACS_OFF_CSRA     4'h6
`define ACS_OFF_MUX      4'h7
`define ACS_OFF_IRQ_STAT 4'h8
`define ACS_OFF_IRQ_MASK 4'h9
`define ACS_OFF_RESULT_L 4'ha
`define ACS_OFF_RESULT_H 4'hb

// ----------------------------------------
// Control register A fields
// ----------------------------------------
`define ACS_A_EN    7
`define ACS_A_START 6
`define ACS_A_ATE   5
`define ACS_A_DONE  4
`define ACS_A_IE    3
`define ACS_A_PS_HI 2
`define ACS_A_PS_LO 0

// ----------------------------------------
// Control register B fields
// ----------------------------------------
`define ACS_B_HIGH_GAIN_SELECT  6
`define ACS_B_CHANNEL_SELECT_HIGH  3
`define ACS_B_TS_HI 2
`define ACS_B_TS_LO 0
`define ACS_B_MASK  8'h4f

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ACS_RST_8       8'h00
`define ACS_TS_FREE     3'h0
`define ACS_MUX_MASK    8'h1f
`define ACS_SE_LAST     6'h0a
`define ACS_SE_BANDGAP  6'h1e
`define ACS_SE_GROUND   6'h1f
`define ACS_SE_TEMP     6'h3f
`define ACS_HIGH_BASE   6'h20
`define ACS_SAME_BASE   6'h38

// ----------------------------------------
// Conversion lengths in converter clocks
// ----------------------------------------
`define ACS_CYC_FIRST   5'd25
`define ACS_CYC_NORMAL  5'd13

`endif

// ---- acs_pkg.sv ----
/*
  Types shared by the converter channel select and control block.
  Assumes acs_regs.svh is on the include path.
*/
package acs_pkg;
  `include "acs_regs.svh"

  typedef enum logic [2:0] {
    ACS_SRC_NONE = 3'h0,
    ACS_SRC_SINGLE = 3'h1,
    ACS_SRC_DIFF = 3'h2,
    ACS_SRC_BANDGAP = 3'h3,
    ACS_SRC_GROUND = 3'h4,
    ACS_SRC_TEMP = 3'h5
  } acs_src_t;

  typedef enum logic [1:0] {
    ACS_GAIN_1X = 2'h0,
    ACS_GAIN_8X = 2'h1,
    ACS_GAIN_20X = 2'h2,
    ACS_GAIN_32X = 2'h3
  } acs_gain_t;

  typedef struct packed {
    acs_src_t src;
    logic [3:0] single_ch;
    logic [3:0] pos_ch;
    logic [3:0] neg_ch;
    acs_gain_t gain;
    logic temp_en;
  } acs_route_t;

  typedef enum logic [1:0] {
    ACS_ST_OFF = 2'b00,
    ACS_ST_IDLE = 2'b01,
    ACS_ST_CONV = 2'b11
  } acs_state_t;
endpackage

// ---- acs_route_decode.sv ----
/*
  Decodes the six-bit channel and gain code into an analog routing word.
  Assumes a code that is stable, already latched at conversion start.
*/
`timescale 1ns/1ps
module acs_route_decode
  import acs_pkg::*;
(
  // Selection
  input wire logic [5:0] code,
  input wire logic high_gain_select,
  // Routing
  output acs_route_t route
);

  // Differential pairs for codes 0b..1d, indexed by code - 0b
  function automatic logic [7:0] low_pair(input logic [4:0] idx);
    case (idx)
      5'h00, 5'h01: low_pair = 8'h01;
      5'h02: low_pair = 8'h11;
      5'h03, 5'h04: low_pair = 8'h21;
      5'h05: low_pair = 8'h23;
      5'h06: low_pair = 8'h33;
      5'h07, 5'h08: low_pair = 8'h43;
      5'h09, 5'h0a: low_pair = 8'h45;
      5'h0b: low_pair = 8'h55;
      5'h0c, 5'h0d: low_pair = 8'h65;
      5'h0e, 5'h0f: low_pair = 8'h89;
      5'h10: low_pair = 8'h99;
      default: low_pair = 8'ha9;
    endcase
  endfunction

  // Pairs for codes 20..37, two codes per pair
  function automatic logic [7:0] high_pair(input logic [3:0] idx);
    case (idx)
      4'h0: high_pair = 8'h01;
      4'h1: high_pair = 8'h10;
      4'h2: high_pair = 8'h12;
      4'h3: high_pair = 8'h21;
      4'h4: high_pair = 8'h20;
      4'h5: high_pair = 8'h02;
      4'h6: high_pair = 8'h45;
      4'h7: high_pair = 8'h54;
      4'h8: high_pair = 8'h56;
      4'h9: high_pair = 8'h65;
      4'ha: high_pair = 8'h64;
      default: high_pair = 8'h46;
    endcase
  endfunction

  // Same-pin pairs for codes 38..3e, offset measurement
  function automatic logic [3:0] same_pin(input logic [2:0] idx);
    case (idx)
      3'h0, 3'h1: same_pin = 4'h0;
      3'h2: same_pin = 4'h1;
      3'h3: same_pin = 4'h2;
      3'h4: same_pin = 4'h4;
      3'h5: same_pin = 4'h5;
      default: same_pin = 4'h6;
    endcase
  endfunction

  wire logic [4:0] low_idx = 5'(code[4:0] - 5'h0b);
  wire logic [5:0] high_off = 6'(code - `ACS_HIGH_BASE);
  wire logic [2:0] same_idx = 3'(code - `ACS_SAME_BASE);
  wire logic [7:0] lp = low_pair(low_idx);
  wire logic [7:0] hp = high_pair(high_off[4:1]);
  wire logic [3:0] sp = same_pin(same_idx);
  // Code 39 alone has the low gain pair among the same-pin codes
  wire logic hi_low_gain = (code >= `ACS_SAME_BASE) ? (code == 6'h39) : code[0];
  // The 1x codes of the low table are listed by code; all other low codes are 20x
  wire logic lo_unity = (code == 6'h0c) || (code == 6'h0f) || (code == 6'h10) || (code == 6'h13) ||
                        (code == 6'h15) || (code == 6'h18) || (code == 6'h1a) || (code == 6'h1d);

  always_comb begin
    // Every code routes something defined; fields a code leaves unused stay zero
    route = '0; // RULE_19
    if (code <= `ACS_SE_LAST) begin
      route.src = ACS_SRC_SINGLE; // RULE_03
      route.single_ch = code[3:0];
    end else if (code == `ACS_SE_BANDGAP) begin
      route.src = ACS_SRC_BANDGAP; // RULE_04
    end else if (code == `ACS_SE_GROUND) begin
      route.src = ACS_SRC_GROUND; // RULE_04
    end else if (code == `ACS_SE_TEMP) begin
      route.src = ACS_SRC_TEMP; // RULE_07
      route.single_ch = 4'hb;
      route.temp_en = 1'b1;
    end else if (!code[5]) begin
      route.src = ACS_SRC_DIFF; // RULE_05
      route.pos_ch = lp[7:4];
      route.neg_ch = lp[3:0]; // RULE_06
      route.gain = lo_unity ? ACS_GAIN_1X : ACS_GAIN_20X;
    end else begin
      route.src = ACS_SRC_DIFF;
      route.pos_ch = (code >= `ACS_SAME_BASE) ? sp : hp[7:4];
      route.neg_ch = (code >= `ACS_SAME_BASE) ? sp : hp[3:0]; // RULE_06
      if (hi_low_gain) begin
        route.gain = high_gain_select ? ACS_GAIN_8X : ACS_GAIN_1X; // RULE_16
      end else begin
        route.gain = high_gain_select ? ACS_GAIN_32X : ACS_GAIN_20X; // RULE_16
      end
    end
  end

endmodule

// ---- acs_clk_div.sv ----
/*
  Converter clock prescaler: a one-cycle tick at the selected division.
  Assumes it is held cleared while the converter is off.
*/
`timescale 1ns/1ps
module acs_clk_div #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Control
  input wire logic run,
  input wire logic [2:0] divider,
  // Tick
  output logic tick
);

  logic [WIDTH-1:0] cnt_reg;
  wire logic [WIDTH-1:0] limit = (divider == 3'h0) ? WIDTH'(1) : WIDTH'((1 << divider) - 1);
  wire logic wrap = (cnt_reg >= limit);

  always_ff @(posedge REF_CLK) begin
    if (!RST_N || !run || wrap) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + WIDTH'(1);
    end
  end

  assign tick = run && wrap;

endmodule

// ---- acs_top.sv ----
/*
  Converter channel select and control: register file, conversion sequencer,
  latched routing to the analog front end and a done interrupt.
  Assumes the analog core returns a result word at conversion end and that the
  trigger inputs are already on REF_CLK.
*/
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
// Operation
// RULE_01: Six-bit code from low and high bits
// RULE_02: New selection applies only after conversion ends
// RULE_03: Codes 0 to 10 pick single inputs
// RULE_04: Codes 1e,1f give reference and ground
// RULE_05: Differential codes fix pair and gain
// RULE_06: Same pin on both inputs allowed
// RULE_07: Code 3f selects temperature sensor channel
// RULE_08: Enable powers on; clearing aborts conversion
// RULE_09: Software starts each single conversion
// RULE_10: Free running restarts without further writes; code restarts only when the done flag rises, not while it stays set
// RULE_11: First conversion 25 cycles, later 13
// RULE_12: Start bit reads one while converting
// RULE_13: Writing zero to start is ignored
// RULE_14: Auto trigger on selected rising edge
// RULE_15: High bit is code most significant bit
// RULE_16: Gain select swaps 32x/8x for 20x/1x
// RULE_17: Done flag sets at end, cleared by one
// RULE_18: Switching to free running makes no trigger
// RULE_19: Not-applicable codes treated as reserved
module acs_top
  import acs_pkg::*;
#(
  parameter int DIV_WIDTH = 7,
  parameter int RESULT_WIDTH = 10
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Trigger sources, indexed by trigger select
  input wire logic [7:0] TRIG_IN,
  // Interrupt vector taken
  input wire logic IRQ_ACK,
  // Analog core
  input wire logic [RESULT_WIDTH-1:0] CORE_RESULT,
  output acs_route_t ROUTE,
  output logic CORE_POWER,
  output logic CORE_SAMPLE,
  output logic CORE_INIT,
  // Interrupt
  output logic IRQ
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] csra_reg;
  logic [7:0] csrb_reg;
  logic [7:0] mux_reg;
  logic [7:0] mask_reg;
  logic [7:0] rdata_reg;
  logic [RESULT_WIDTH-1:0] result_reg;
  logic [5:0] active_code_reg;
  logic active_high_gain_select_reg;
  logic [4:0] cyc_reg;
  logic [4:0] len_reg;
  logic first_reg;
  logic trig_d_reg;
  logic [2:0] ts_d_reg;
  acs_state_t state_reg;
  acs_state_t state_next;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic wr_a = WR && (ADDR == `ACS_OFF_CSRA);
  wire logic wr_b = WR && (ADDR == `ACS_OFF_B);
  wire logic wr_mux = WR && (ADDR == `ACS_OFF_MUX);
  wire logic wr_stat = WR && (ADDR == `ACS_OFF_IRQ_STAT);
  wire logic wr_mask = WR && (ADDR == `ACS_OFF_IRQ_MASK);

  wire logic en = csra_reg[`ACS_A_EN];
  wire logic en_new = wr_a ? WDATA[`ACS_A_EN] : en;
  wire logic ate = csra_reg[`ACS_A_ATE];
  wire logic done_flag = csra_reg[`ACS_A_DONE];
  wire logic [2:0] ts = csrb_reg[`ACS_B_TS_HI:`ACS_B_TS_LO];
  wire logic [2:0] ps = csra_reg[`ACS_A_PS_HI:`ACS_A_PS_LO];

  // Live six-bit selection code
  wire logic [5:0] live_code = {csrb_reg[`ACS_B_CHANNEL_SELECT_HIGH], mux_reg[4:0]}; // RULE_01 RULE_15

  // ----------------------------------------
  // Trigger
  // ----------------------------------------
  // Free running uses the done flag as its own trigger source
  wire logic trig_sel = (ts == `ACS_TS_FREE) ? done_flag : TRIG_IN[ts];
  // Edge is suppressed when moving into free running
  wire logic trig_edge = trig_sel && !trig_d_reg &&
                         !((ts == `ACS_TS_FREE) && (ts_d_reg != `ACS_TS_FREE)); // RULE_18
  wire logic auto_start = ate && trig_edge; // RULE_14 RULE_10

  wire logic sw_start = wr_a && WDATA[`ACS_A_START] && en_new; // RULE_09 RULE_13
  wire logic conv_busy = (state_reg == ACS_ST_CONV);
  wire logic tick;
  wire logic conv_end = conv_busy && tick && (cyc_reg == len_reg - 5'd1);
  wire logic start_go = en_new && !conv_busy && (sw_start || auto_start);

  acs_clk_div #(
    .WIDTH(DIV_WIDTH)
  ) u_div (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .run(conv_busy),
    .divider(ps),
    .tick(tick)
  );

  acs_route_decode u_dec (
    .code(active_code_reg),
    .high_gain_select(active_high_gain_select_reg),
    .route(ROUTE)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ACS_ST_OFF: begin
        if (start_go) begin
          state_next = ACS_ST_CONV;
        end else if (en_new) begin
          state_next = ACS_ST_IDLE;
        end
      end
      ACS_ST_IDLE: begin
        if (!en_new) begin
          state_next = ACS_ST_OFF;
        end else if (start_go) begin
          state_next = ACS_ST_CONV;
        end
      end
      ACS_ST_CONV: begin
        if (!en_new) begin
          state_next = ACS_ST_OFF; // RULE_08
        end else if (conv_end) begin
          state_next = ACS_ST_IDLE;
        end
      end
      default: state_next = ACS_ST_OFF;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_reg <= ACS_ST_OFF;
      first_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      // Disabling re-arms the long initialising conversion
      if (!en_new) begin
        first_reg <= 1'b1;
      end else if (start_go) begin
        first_reg <= 1'b0;
      end
    end
  end

  // Converter clock count of the running conversion
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      cyc_reg <= 5'd0;
      len_reg <= `ACS_CYC_NORMAL;
    end else if (start_go) begin
      cyc_reg <= 5'd0;
      len_reg <= first_reg ? `ACS_CYC_FIRST : `ACS_CYC_NORMAL; // RULE_11
    end else if (conv_busy && tick) begin
      cyc_reg <= cyc_reg + 5'd1;
    end
  end

  // Selection is latched only at start, so writes mid-conversion wait
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      active_code_reg <= 6'h00;
      active_high_gain_select_reg <= 1'b0;
    end else if (start_go) begin
      active_code_reg <= live_code; // RULE_02
      active_high_gain_select_reg <= csrb_reg[`ACS_B_HIGH_GAIN_SELECT];
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Set wins over a same-cycle clear, so a finishing conversion is never lost
  wire logic done_set = conv_end && en_new; // RULE_17
  wire logic done_clr_a = wr_a && WDATA[`ACS_A_DONE];
  wire logic done_clr_stat = wr_stat && WDATA[0];
  wire logic done_clr = done_clr_a || done_clr_stat || IRQ_ACK; // RULE_17
  wire logic busy_next = (state_next == ACS_ST_CONV);

  // Previous trigger level and source, for edge detection
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      trig_d_reg <= 1'b0;
      ts_d_reg <= `ACS_TS_FREE;
    end else begin
      trig_d_reg <= trig_sel;
      ts_d_reg <= ts;
    end
  end

  // ----------------------------------------
  // Control register A
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      csra_reg <= `ACS_RST_8;
    end else begin
      if (wr_a) begin
        csra_reg[`ACS_A_EN] <= WDATA[`ACS_A_EN]; // RULE_08
        csra_reg[`ACS_A_ATE] <= WDATA[`ACS_A_ATE];
        csra_reg[`ACS_A_IE] <= WDATA[`ACS_A_IE];
        csra_reg[`ACS_A_PS_HI:`ACS_A_PS_LO] <= WDATA[`ACS_A_PS_HI:`ACS_A_PS_LO];
      end
      // Start bit mirrors the busy state, so a zero write has no hold on it
      csra_reg[`ACS_A_START] <= busy_next; // RULE_12 RULE_13
      if (done_set) begin
        csra_reg[`ACS_A_DONE] <= 1'b1; // RULE_17
      end else if (done_clr) begin
        csra_reg[`ACS_A_DONE] <= 1'b0; // RULE_17
      end
    end
  end

  // An abort leaves the last completed result in place
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      result_reg <= '0;
    end else if (done_set) begin
      result_reg <= CORE_RESULT;
    end
  end

  // ----------------------------------------
  // Control register B, selection and mask
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      csrb_reg <= `ACS_RST_8;
      mux_reg <= `ACS_RST_8;
      mask_reg <= `ACS_RST_8;
    end else begin
      if (wr_b) begin
        csrb_reg <= WDATA & `ACS_B_MASK;
      end
      if (wr_mux) begin
        mux_reg <= WDATA & `ACS_MUX_MASK;
      end
      if (wr_mask) begin
        mask_reg <= {7'h00, WDATA[0]};
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire logic [15:0] result_w = 16'(result_reg);
  wire logic [7:0] rd_mux =
    (ADDR == `ACS_OFF_CSRA) ? csra_reg :
    (ADDR == `ACS_OFF_B) ? csrb_reg :
    (ADDR == `ACS_OFF_MUX) ? mux_reg :
    (ADDR == `ACS_OFF_IRQ_STAT) ? {7'h00, done_flag} :
    (ADDR == `ACS_OFF_IRQ_MASK) ? mask_reg :
    (ADDR == `ACS_OFF_RESULT_L) ? result_w[7:0] :
    (ADDR == `ACS_OFF_RESULT_H) ? result_w[15:8] : 8'h00;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= RD ? rd_mux : 8'h00;
    end
  end

  assign RDATA = rdata_reg;
  assign CORE_POWER = en;
  assign CORE_SAMPLE = conv_busy;
  assign CORE_INIT = conv_busy && (len_reg == `ACS_CYC_FIRST);
  // Either enable bit unmasks the done event
  assign IRQ = done_flag && (csra_reg[`ACS_A_IE] || mask_reg[0]);

endmodule

// ---- acs_core_model.sv ----
/*
  Behavioural analog core: returns a result word derived from the route.
  Assumes the sample line stays high for the whole conversion.
*/
`timescale 1ns/1ps
module acs_core_model
  import acs_pkg::*;
(
  // Control from the block
  input wire logic ref_clk,
  input wire logic sample,
  input wire acs_route_t route,
  // Result
  output logic [9:0] result
);
  logic busy_reg = 1'b0;
  logic [9:0] res_reg = 10'h000;
  assign result = res_reg;
  // Toggles outside a conversion so that a stale sample cannot pass
  always @(posedge ref_clk) begin
    busy_reg <= sample;
    if (!sample) begin
      res_reg <= ~res_reg;
    end else if (!busy_reg) begin
      res_reg <= route[9:0] ^ 10'h155;
    end
  end
endmodule

// ---- acs_top_checker.sv ----
/*
  Port-level checks of the converter select and control block.
  Assumes it is bound to acs_top and sees only its ports.
*/
`timescale 1ns/1ps
module acs_top_checker
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Core and interrupt
  input wire logic IRQ_ACK,
  input wire acs_route_t ROUTE,
  input wire logic CORE_POWER,
  input wire logic CORE_SAMPLE,
  input wire logic CORE_INIT,
  input wire logic IRQ
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  wire en_bit = WDATA[7];
  wire go_bit = WDATA[6];
  wire ctl_a = (ADDR == 4'h6);
  property p_rd_idle;
    !$past(RD) |-> RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_rd_busy;
    $past(RD) && $past(ctl_a) |-> RDATA[6] == $past(CORE_SAMPLE);
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("start bit wrong");
  property p_power_wr;
    $past(WR) && $past(ctl_a) |-> CORE_POWER == $past(en_bit);
  endproperty
  a_power_wr: assert property (p_power_wr) else $error("power wrong");
  property p_start_wr;
    $past(WR) && $past(ctl_a) && $past(en_bit) && $past(go_bit) && !$past(CORE_SAMPLE) |-> CORE_SAMPLE;
  endproperty
  a_start_wr: assert property (p_start_wr) else $error("no start");
  property p_off;
    !CORE_POWER |-> !CORE_SAMPLE;
  endproperty
  a_off: assert property (p_off) else $error("converting while off");
  property p_hold;
    CORE_SAMPLE && $past(CORE_SAMPLE) |-> $stable(ROUTE);
  endproperty
  a_hold: assert property (p_hold) else $error("route moved");
  property p_init;
    CORE_INIT |-> CORE_SAMPLE;
  endproperty
  a_init: assert property (p_init) else $error("init outside");
  property p_first;
    $rose(CORE_SAMPLE) && !$past(CORE_POWER) |-> CORE_INIT;
  endproperty
  a_first: assert property (p_first) else $error("no init");
  property p_ack;
    $past(IRQ_ACK) && !$fell(CORE_SAMPLE) |-> !IRQ;
  endproperty
  a_ack: assert property (p_ack) else $error("ack kept irq");
  property p_irq_cause;
    $rose(IRQ) && !$past(WR) |-> $fell(CORE_SAMPLE);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq no cause");
endmodule
bind acs_top acs_top_checker acs_top_checker_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_ACK(IRQ_ACK), .ROUTE(ROUTE),
  .CORE_POWER(CORE_POWER), .CORE_SAMPLE(CORE_SAMPLE), .CORE_INIT(CORE_INIT), .IRQ(IRQ));

// ---- tb_acs_top.sv ----
/*
  Self-checking bench: registers, routing table, conversions, triggers.
  Assumes package, design, core model and checker are compiled first.
*/
`timescale 1ns/1ps
module tb_acs_top;
  import acs_pkg::*;
  logic ref_clk, rst_n, wr, rd, irq_ack, core_power, core_sample, core_init, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, trig_in, d;
  logic [9:0] core_result, r;
  acs_route_t route;
  int failures, comparisons, n, dv, t;
  time ts;
  // Code, gain select, expected route, fields that matter
  logic [5:0] code [10] = '{6'h00, 6'h0a, 6'h0c, 6'h0d, 6'h1e, 6'h1f, 6'h22, 6'h23, 6'h23, 6'h3f};
  logic [9:0] gs = 10'b0101000000;
  logic [17:0] ex [10] = '{18'h08000, 18'h0d000, 18'h10008, 18'h1008c, 18'h18000, 18'h20000,
    18'h10086, 18'h10080, 18'h10082, 18'h2d801};
  logic [17:0] mk [10] = '{18'h3f801, 18'h3f801, 18'h387ff, 18'h387ff, 18'h38001, 18'h38001,
    18'h387ff, 18'h387ff, 18'h387ff, 18'h3f801};
  acs_top acs_top_i (.REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .TRIG_IN(trig_in), .IRQ_ACK(irq_ack), .CORE_RESULT(core_result),
    .ROUTE(route), .CORE_POWER(core_power), .CORE_SAMPLE(core_sample), .CORE_INIT(core_init),
    .IRQ(irq));
  acs_core_model acs_core_model_i (.ref_clk(ref_clk), .sample(core_sample), .route(route),
    .result(core_result));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic wait_s(input logic v);
    n = 0;
    while (core_sample !== v && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  task automatic go(input logic [7:0] c, input int len);
    t = len;
    dv = (c[2:0] < 3'h2) ? 2 : (1 << c[2:0]);
    wr_reg(4'h6, c);
    ts = $time;
    chk(core_sample, 1'b1);
    chk(core_init, len == 25);
  endtask
  task automatic fin();
    wait_s(1'b0);
    n = int'(($time - ts) / 10);
    chk(n >= (t - 1) * dv && n <= (t + 1) * dv, 1'b1);
  endtask
  task automatic sel(input int i);
    wr_reg(4'h3, {1'b0, gs[i], 2'b00, code[i][5], 3'h0});
    wr_reg(4'h7, {3'h0, code[i][4:0]});
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    conclude();
  end
  initial begin
    {rst_n, wr, rd, irq_ack} = 4'h0;
    addr = 4'h0;
    wdata = 8'h00;
    trig_in = 8'h00;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 3; a < 12; a++) begin
      rd_reg(a[3:0], d);
      chk(d, 8'h00);
    end
    chk(route & mk[0], ex[0]);
    wr_reg(4'h5, 8'hff);
    rd_reg(4'h5, d);
    chk(d, 8'h00);
    wr_reg(4'h3, 8'hff);
    rd_reg(4'h3, d);
    chk(d, 8'h4f);
    $display("test registers done");
    // Mid-conversion selection writes must wait for the next start
    sel(0);
    for (int i = 0; i < 10; i++) begin
      go(8'hc0, i == 0 ? 25 : 13);
      sel((i + 1) % 10);
      wr_reg(4'h6, 8'h80);
      rd_reg(4'h6, d);
      chk(d, 8'hc0);
      chk(route & mk[i], ex[i]);
      fin();
      rd_reg(4'h6, d);
      chk(d, 8'h90);
      r = ex[i][9:0] ^ 10'h155;
      if (mk[i] == 18'h387ff) begin
        rd_reg(4'ha, d);
        chk(d, r[7:0]);
        rd_reg(4'hb, d);
        chk(d, {6'h00, r[9:8]});
      end
      wr_reg(4'h6, 8'h90);
    end
    $display("test routing done");
    wr_reg(4'h9, 8'h01);
    go(8'hc0, 13);
    fin();
    chk(irq, 1'b1);
    rd_reg(4'h8, d);
    chk(d, 8'h01);
    wr_reg(4'h9, 8'h00);
    chk(irq, 1'b0);
    wr_reg(4'h6, 8'h88);
    chk(irq, 1'b1);
    wr_reg(4'h8, 8'h01);
    chk(irq, 1'b0);
    wr_reg(4'h9, 8'h01);
    go(8'hc0, 13);
    fin();
    @(posedge ref_clk);
    irq_ack <= 1'b1;
    @(posedge ref_clk);
    irq_ack <= 1'b0;
    #1;
    chk(irq, 1'b0);
    $display("test interrupt done");
    go(8'hc0, 13);
    wr_reg(4'h6, 8'h00);
    chk({core_power, core_sample}, 2'b00);
    rd_reg(4'h6, d);
    chk(d, 8'h00);
    go(8'hc3, 25);
    fin();
    go(8'hc3, 13);
    fin();
    $display("test abort done");
    wr_reg(4'h6, 8'hb0);
    wr_reg(4'h3, 8'h02);
    @(posedge ref_clk);
    trig_in <= 8'h08;
    repeat (4) @(posedge ref_clk);
    trig_in <= 8'h0c;
    #1;
    chk(core_sample, 1'b0);
    wait_s(1'b1);
    chk(n < 4, 1'b1);
    wait_s(1'b0);
    // Source line low first, so only the suppression can hold back a start
    @(posedge ref_clk);
    trig_in <= 8'h00;
    wr_reg(4'h3, 8'h00);
    repeat (6) @(posedge ref_clk);
    #1;
    chk(core_sample, 1'b0);
    go(8'hf0, 13);
    fin();
    wait_s(1'b1);
    chk(n < 4, 1'b1);
    wait_s(1'b0);
    $display("test triggers done");
    conclude();
  end
endmodule
